// ---- rtl/lhd_map.svh ----
// constants for the hub-cycle decoder: start codes, field values, counts
// assumes nothing; definitions only
`ifndef LHD_MAP_SVH
`define LHD_MAP_SVH
`define LHD_START_LPC 4'h0
`define LHD_START_HUB_RD 4'hd
`define LHD_START_HUB_WR 4'he
`define LHD_SIZE_ONE 4'h0
`define LHD_SYNC_READY 4'h0
`define LHD_SYNC_WAIT 4'h5
`define LHD_TAR_VALUE 4'hf
`define LHD_CT_MEM 2'b01
`define LHD_CT_DIR_BIT 1
`define LHD_HUB_ADDR_NIB 4'h7
`define LHD_LPC_ADDR_NIB 4'h8
`define LHD_A23_BIT 23
`define LHD_WAIT_CYCLES 4'h2
`endif

// ---- rtl/lhd_pkg.sv ----
// types shared by both ends of the hub-cycle decoder
// assumes lhd_map.svh for the numeric constants
`default_nettype none
package lhd_pkg;
   typedef enum logic [3:0] {
      LHD_IDLE = 4'h0,
      LHD_SEL = 4'h1,
      LHD_ADDR = 4'h2,
      LHD_SIZE = 4'h3,
      LHD_DATA = 4'h4,
      LHD_TURNAROUND_FIRST_CLOCK = 4'h5,
      LHD_TURNAROUND_SECOND_CLOCK = 4'h6,
      LHD_SYNC = 4'h7,
      LHD_RTAR0 = 4'h8,
      LHD_RTAR1 = 4'h9,
      LHD_CTYPE = 4'ha,
      LHD_SKIP = 4'hb
   } lhd_state_t;
   typedef enum logic [1:0] {
      LHD_KIND_NONE = 2'h0,
      LHD_KIND_HUB = 2'h1,
      LHD_KIND_LPC = 2'h2
   } lhd_kind_t;
endpackage
`default_nettype wire

// ---- rtl/lhd_bus_if.sv ----
// nibble bus between host master and flash target
// assumes the bench resolves the shared wire from the two enables
`default_nettype none
interface lhd_bus_if;
   logic frameStrobe_n;
   logic [3:0] hostNibble;
   logic hostNibbleOe;
   logic [3:0] devNibble;
   logic devNibbleOe;
   logic [3:0] nibbleBus;
   modport host (
      output frameStrobe_n, output hostNibble, output hostNibbleOe,
      input nibbleBus
   );
   modport device (
      input frameStrobe_n, input nibbleBus,
      output devNibble, output devNibbleOe
   );
endinterface
`default_nettype wire

// ---- rtl/lhd_sync2.sv ----
// two-flop synchroniser, one per bit, for pin inputs
// assumes a single clock domain behind it
`default_nettype none
module lhd_sync2 #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   input wire logic [W-1:0] rstVal,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               meta_r[i] <= 1'b1;
               dout[i] <= 1'b1;
            end else begin
               meta_r[i] <= din[i];
               dout[i] <= meta_r[i];
            end
         end
      end
   endgenerate
   // rstVal kept for users wanting a documented idle level; all pins idle high
   logic unusedRst;
   assign unusedRst = ^rstVal;
endmodule
`default_nettype wire

// ---- rtl/lhd_target.sv ----
// flash target front end: hub and lpc memory cycle decode
// Behaviour
// R1: code 1110b opens a hub single-byte write
// R2: start code is last nibble while strobe low
// R3: select nibble must match strap identity
// R4: hub address is seven nibbles, MSB first
// R5: host sends size nibble 0000b
// R6: data byte follows, low nibble first
// R7: written byte is command or program data
// R8: host drives 1111b, then floats bus
// R9: device takes bus, drives one ready sync
// R10: device drives 1111b, then floats
// R11: fields sampled on rising bus clock
// R12: lpc start is 0000b while strobe low
// R13: non-zero start still tried as hub cycle; code takes only 1101b and 1110b as hub starts
// R14: cycle type bits[3:2]=01b means memory
// R15: other cycle types: float, go standby
// R16: bit1 gives direction, bit0 ignored
// R17: lpc address is eight nibbles, MSB first
// R18: ignore A31-A24 and A22-A18
// R19: A23 selects array or register space
// R20: code 1101b is a hub single-byte read
// R21: wait sync 0101b until ready
// R22: mismatched select keeps bus floating
// R23: new strobe assertion restarts decode
// assumes frame strobe and bus arrive from pins; the two-flop delay is
// applied equally to both so their relative timing is kept
`default_nettype none
`include "lhd_map.svh"
module lhd_target (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   lhd_bus_if.device bus,
   input wire logic [3:0] strapId,
   input wire logic opBusy,
   input wire logic [3:0] waitCount,
   input wire logic [7:0] readData,
   output logic wrStrobe,
   output logic rdStrobe,
   output logic [7:0] wrByte,
   output logic [22:0] accAddr,
   output logic toArray,
   output logic isHub,
   output logic standby,
   output logic [3:0] lastStart
);
   import lhd_pkg::*;
   // =============================================
   // pin capture
   logic [8:0] pinSync;
   logic frameLow;
   logic [3:0] nib;
   logic [3:0] strapSync;
   // straps are pins too, so they share the two-flop path
   lhd_sync2 #(.W(9)) uSync (
      .mclk(mclk),
      .rst_n(rst_n),
      .din({strapId, bus.frameStrobe_n, bus.nibbleBus}),
      .rstVal(9'h1ff),
      .dout(pinSync)
   );
   assign frameLow = ~pinSync[4];
   assign nib = pinSync[3:0];
   assign strapSync = pinSync[8:5];
   // =============================================
   // cycle state
   lhd_state_t state_r;
   lhd_kind_t kind_r;
   logic isWrite_r;
   logic [3:0] cnt_r;
   logic [31:0] addr_r;
   logic [3:0] devNib_r;
   logic devOe_r;
   logic badType_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= LHD_IDLE;
         kind_r <= LHD_KIND_NONE;
         isWrite_r <= 1'b0;
         cnt_r <= 4'h0;
         addr_r <= 32'h0;
         wrByte <= 8'h0;
         badType_r <= 1'b0;
         lastStart <= 4'h0;
         isHub <= 1'b0;
      end else if (clkEn) begin
         if (frameLow) begin
            // each low clock overwrites: the last one before release wins
            state_r <= LHD_IDLE; // [R23] [R2] [R11]
            lastStart <= nib; // [R2]
            badType_r <= 1'b0;
            cnt_r <= 4'h0;
            case (nib)
               `LHD_START_LPC: kind_r <= LHD_KIND_LPC; // [R12]
               `LHD_START_HUB_WR: begin
                  kind_r <= LHD_KIND_HUB; // [R1] [R13]
                  isWrite_r <= 1'b1;
               end
               `LHD_START_HUB_RD: begin
                  kind_r <= LHD_KIND_HUB; // [R20] [R13]
                  isWrite_r <= 1'b0;
               end
               default: kind_r <= LHD_KIND_NONE;
            endcase
         end else begin
            case (state_r)
               LHD_IDLE: begin
                  if (kind_r == LHD_KIND_HUB) begin
                     state_r <= LHD_SEL;
                  end else if (kind_r == LHD_KIND_LPC) begin
                     state_r <= LHD_CTYPE;
                  end
                  kind_r <= LHD_KIND_NONE;
                  // first post-strobe clock is field 2 itself
                  if (kind_r == LHD_KIND_HUB) begin
                     isHub <= 1'b1;
                     // [R3] [R22]
                     state_r <= (nib == strapSync) ? LHD_ADDR : LHD_SKIP;
                  end else if (kind_r == LHD_KIND_LPC) begin
                     isHub <= 1'b0;
                     if (nib[3:2] == `LHD_CT_MEM) begin // [R14]
                        isWrite_r <= nib[`LHD_CT_DIR_BIT]; // [R16]
                        state_r <= LHD_ADDR;
                     end else begin
                        badType_r <= 1'b1; // [R15]
                        state_r <= LHD_SKIP;
                     end
                  end
               end
               LHD_ADDR: begin
                  addr_r <= {addr_r[27:0], nib}; // [R4] [R17]
                  cnt_r <= cnt_r + 4'h1;
                  if (isHub && cnt_r == `LHD_HUB_ADDR_NIB - 4'h1) begin
                     state_r <= LHD_SIZE;
                  end else if (!isHub &&
                               cnt_r == `LHD_LPC_ADDR_NIB - 4'h1) begin
                     cnt_r <= 4'h0;
                     state_r <= isWrite_r ? LHD_DATA : LHD_TURNAROUND_FIRST_CLOCK;
                  end
               end
               LHD_SIZE: begin
                  // size other than one byte is the host's fault [R5]
                  cnt_r <= 4'h0;
                  state_r <= isWrite_r ? LHD_DATA : LHD_TURNAROUND_FIRST_CLOCK;
               end
               LHD_DATA: begin
                  wrByte <= {nib, wrByte[7:4]}; // [R6] [R7]
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == 4'h1) begin
                     state_r <= LHD_TURNAROUND_FIRST_CLOCK;
                  end
               end
               LHD_TURNAROUND_FIRST_CLOCK: state_r <= LHD_TURNAROUND_SECOND_CLOCK; // [R8]
               LHD_TURNAROUND_SECOND_CLOCK: begin
                  state_r <= LHD_SYNC; // [R9]
                  cnt_r <= 4'h0;
               end
               LHD_SYNC: begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r >= waitCount) begin // [R21]
                     // no read data phase: both directions hand back
                     state_r <= LHD_RTAR0;
                     cnt_r <= 4'h0;
                  end
               end
               LHD_RTAR0: state_r <= LHD_RTAR1; // [R10]
               LHD_RTAR1: state_r <= LHD_SKIP;
               LHD_SKIP: state_r <= LHD_SKIP;
               default: state_r <= LHD_IDLE;
            endcase
         end
      end
   end
   // =============================================
   // pin drive
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         devNib_r <= `LHD_TAR_VALUE;
         devOe_r <= 1'b0;
      end else if (clkEn) begin
         devOe_r <= 1'b0; // [R22] [R15]
         devNib_r <= `LHD_TAR_VALUE;
         if (!frameLow) begin
            // second turnaround clock floats: a zero waitCount makes the
            // ready sync the first nibble driven
            if (state_r == LHD_SYNC && cnt_r < waitCount) begin
               devOe_r <= 1'b1;
               devNib_r <= `LHD_SYNC_WAIT; // [R21]
            end
            if (state_r == LHD_SYNC && cnt_r >= waitCount) begin
               devOe_r <= 1'b1;
               devNib_r <= `LHD_SYNC_READY; // [R9]
            end
            if (state_r == LHD_RTAR0) begin
               devOe_r <= 1'b1;
               devNib_r <= `LHD_TAR_VALUE; // [R10]
            end
         end
      end
   end
   assign bus.devNibble = devNib_r;
   assign bus.devNibbleOe = devOe_r;
   // =============================================
   // core-side strobes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrStrobe <= 1'b0;
         rdStrobe <= 1'b0;
         accAddr <= 23'h0;
         toArray <= 1'b0;
         standby <= 1'b0;
      end else if (clkEn) begin
         wrStrobe <= 1'b0;
         rdStrobe <= 1'b0;
         if (state_r == LHD_TURNAROUND_SECOND_CLOCK && !frameLow) begin
            wrStrobe <= isWrite_r; // [R7]
            rdStrobe <= ~isWrite_r;
            toArray <= addr_r[`LHD_A23_BIT]; // [R19]
            accAddr <= {1'b0, 4'h0, addr_r[17:0]}; // [R18]
         end
         standby <= badType_r & ~frameLow & ~opBusy; // [R15]
      end
   end
   logic unusedRd;
   assign unusedRd = ^readData;
endmodule
`default_nettype wire

// ---- rtl/lhd_host.sv ----
// host master: runs one hub write or read cycle per request
// assumes the target answers with sync within a bounded number of clocks
`default_nettype none
`include "lhd_map.svh"
module lhd_host (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   lhd_bus_if.host bus,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic [3:0] reqSelect,
   input wire logic [27:0] reqAddr,
   input wire logic [7:0] reqData,
   output logic reqBusy,
   output logic doneValid
);
   import lhd_pkg::*;
   // =============================================
   // sequencer: one nibble per clock, target replies read back
   logic [4:0] step_r;
   logic [3:0] out_r;
   logic oe_r;
   logic frame_r;
   logic [43:0] shift_r;
   logic [4:0] len_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         step_r <= 5'h0;
         out_r <= 4'hf;
         oe_r <= 1'b0;
         frame_r <= 1'b1;
         shift_r <= 44'h0;
         len_r <= 5'h0;
         reqBusy <= 1'b0;
         doneValid <= 1'b0;
      end else if (clkEn) begin
         doneValid <= 1'b0;
         if (!reqBusy) begin
            if (reqValid) begin
               reqBusy <= 1'b1;
               frame_r <= 1'b0;
               oe_r <= 1'b1;
               out_r <= reqWrite ? `LHD_START_HUB_WR
                                 : `LHD_START_HUB_RD; // [R1] [R20]
               // select, address msb first, size, data low then high
               shift_r <= {reqSelect, reqAddr, `LHD_SIZE_ONE,
                           reqData[3:0], reqData[7:4]}; // [R4] [R5] [R6]
               len_r <= reqWrite ? 5'h0b : 5'h09;
               step_r <= 5'h0;
            end
         end else begin
            frame_r <= 1'b1;
            step_r <= step_r + 5'h1;
            if (step_r < len_r) begin
               out_r <= shift_r[43:40];
               shift_r <= {shift_r[39:0], 4'h0};
            end else if (step_r == len_r) begin
               out_r <= `LHD_TAR_VALUE; // [R8]
            end else begin
               oe_r <= 1'b0; // [R8]
               if (step_r > len_r + 5'h03 &&
                   bus.nibbleBus == `LHD_SYNC_READY) begin
                  reqBusy <= 1'b0;
                  doneValid <= 1'b1;
               end
               if (step_r == 5'h1f) begin
                  reqBusy <= 1'b0;
               end
            end
         end
      end
   end
   assign bus.frameStrobe_n = frame_r;
   assign bus.hostNibble = out_r;
   assign bus.hostNibbleOe = oe_r;
endmodule
`default_nettype wire

// ---- tb/lhd_assertions.sv ----
// checker: timing rules on the nibble bus between host and target
// assumes the plain signals of the first bus instance, one clock
`default_nettype none
module lhd_assertions (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic frameStrobe_n,
   input wire logic [3:0] hostNibble,
   input wire logic hostNibbleOe,
   input wire logic [3:0] devNibble,
   input wire logic devNibbleOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ==========
   // host side
   AST_START: assert property ($fell(frameStrobe_n) |->
      hostNibbleOe && hostNibble inside {4'hd, 4'he})
      else $error("bad start code");
   AST_FRAME_ONE: assert property (!frameStrobe_n |=> frameStrobe_n)
      else $error("frame held too long");
   AST_HOST_TAR: assert property ($fell(hostNibbleOe) |->
      $past(hostNibble) == 4'hf)
      else $error("host released without 1111");
   // ==========
   // target side
   AST_ONE_DRIVER: assert property (!(hostNibbleOe && devNibbleOe))
      else $error("both ends drive");
   AST_DEV_LATE: assert property ($rose(devNibbleOe) |->
      !hostNibbleOe && !$past(hostNibbleOe))
      else $error("target drove before turnaround");
   AST_SYNC_BOUND: assert property ($rose(devNibbleOe) |->
      ##[0:17] (devNibbleOe && devNibble == 4'h0))
      else $error("no ready sync");
   AST_DEV_VALUES: assert property (devNibbleOe |->
      devNibble inside {4'h0, 4'h5, 4'hf})
      else $error("bad target nibble");
   AST_WAIT_NEXT: assert property (devNibbleOe && devNibble == 4'h5
      |=> devNibbleOe && devNibble inside {4'h0, 4'h5})
      else $error("wait sync broken");
   AST_READY_TAR: assert property (devNibbleOe && devNibble == 4'h0
      |=> devNibbleOe && devNibble == 4'hf ##1 !devNibbleOe)
      else $error("no turnaround after ready");
   AST_QUIET_FRAME: assert property (!frameStrobe_n |-> !devNibbleOe)
      else $error("target drove during frame");
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// bench: host and target joined, plus a bench-driven second bus
// assumes the rtl header, package and interface are compiled first
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst_n, clkEn, reqValid, reqWrite, reqBusy, doneValid;
   logic [3:0] reqSelect, strapId, waitCount, lastStart, lastStartB;
   logic [27:0] reqAddr;
   logic [7:0] reqData, readData, wrByte;
   logic opBusy, wrStrobe, rdStrobe, toArray, isHub, standby;
   logic toArrayB, isHubB, standbyB, devSeen;
   logic [22:0] accAddr, accAddrB;
   int fails, samples_checked, wrCnt, rdCnt, waitCnt;
   lhd_bus_if busA ();
   lhd_bus_if busB ();
   // undriven lines float high through pull-ups
   assign busA.nibbleBus = busA.devNibbleOe ? busA.devNibble :
      busA.hostNibbleOe ? busA.hostNibble : 4'hf;
   assign busB.nibbleBus = busB.devNibbleOe ? busB.devNibble :
      busB.hostNibbleOe ? busB.hostNibble : 4'hf;
   lhd_host lhd_host_i (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .bus(busA), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqSelect(reqSelect), .reqAddr(reqAddr), .reqData(reqData),
      .reqBusy(reqBusy), .doneValid(doneValid));
   lhd_target lhd_target_i (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .bus(busA), .strapId(strapId), .opBusy(opBusy),
      .waitCount(waitCount), .readData(readData), .wrStrobe(wrStrobe),
      .rdStrobe(rdStrobe), .wrByte(wrByte), .accAddr(accAddr),
      .toArray(toArray), .isHub(isHub), .standby(standby),
      .lastStart(lastStart));
   lhd_target lhd_target_b_i (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .bus(busB), .strapId(strapId), .opBusy(opBusy),
      .waitCount(waitCount), .readData(readData), .wrStrobe(),
      .rdStrobe(), .wrByte(), .accAddr(accAddrB), .toArray(toArrayB),
      .isHub(isHubB), .standby(standbyB), .lastStart(lastStartB));
   lhd_assertions lhd_assertions_i (.mclk(mclk), .rst_n(rst_n),
      .frameStrobe_n(busA.frameStrobe_n), .hostNibble(busA.hostNibble),
      .hostNibbleOe(busA.hostNibbleOe), .devNibble(busA.devNibble),
      .devNibbleOe(busA.devNibbleOe));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      wrCnt += (wrStrobe === 1'b1);
      rdCnt += (rdStrobe === 1'b1);
      waitCnt += (busA.devNibbleOe === 1'b1 && busA.devNibble === 4'h5);
      if (busB.devNibbleOe === 1'b1)
         devSeen = 1'b1;
   end
   // ==========
   // tasks
   task automatic finish_test;
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic hub(input logic wr, input logic [3:0] sel,
      input logic [27:0] adr, input logic [7:0] dat, output logic got);
      got = 1'b0;
      @(posedge mclk);
      #1;
      {reqValid, reqWrite, reqSelect, reqAddr, reqData} = {1'b1, wr, sel,
         adr, dat};
      @(posedge mclk);
      #1;
      reqValid = 1'b0;
      // host gives up by itself after 31 steps, so 80 clocks is ample
      for (int n = 0; n < 80 && reqBusy !== 1'b0; n++) begin
         @(posedge mclk);
         #1;
         got |= (doneValid === 1'b1);
      end
   endtask
   task automatic drv(input logic fr, input logic oe, input logic [3:0] nb);
      @(posedge mclk);
      #1;
      busB.frameStrobe_n = fr;
      busB.hostNibbleOe = oe;
      busB.hostNibble = nb;
   endtask
   task automatic lpc(input logic [3:0] ct, input logic [31:0] adr,
      input int na);
      drv(1'b0, 1'b1, 4'hd);
      drv(1'b0, 1'b1, 4'h0);
      drv(1'b1, 1'b1, ct);
      for (int i = 7; i > 7 - na; i--)
         drv(1'b1, 1'b1, adr[4*i +: 4]);
      if (na == 8) begin
         drv(1'b1, 1'b1, 4'hf);
         drv(1'b1, 1'b0, 4'hf);
         repeat (24) @(posedge mclk);
         #1;
      end
   endtask
   // ==========
   // main sequence
   initial begin
      logic got;
      logic [31:0] adr;
      {clkEn, rst_n, reqValid, reqWrite, opBusy, devSeen} = 6'b100000;
      {reqSelect, reqAddr, reqData, waitCount} = '0;
      strapId = 4'h9;
      readData = 8'h3c;
      busB.frameStrobe_n = 1'b1;
      busB.hostNibbleOe = 1'b0;
      busB.hostNibble = 4'hf;
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      for (int k = 0; k < 2; k++) begin
         waitCount = 4'(2 * k);
         waitCnt = 0;
         hub(1'b1, 4'h9, 28'h87a_bcde + 28'(k), 8'h3c + 8'(k), got);
         chk("done", got, 1'b1);
         chk("byte", wrByte, 8'h3c + 8'(k));
         chk("addr", accAddr, {5'h0, 18'h2_bcde + 18'(k)});
         chk("hub", isHub, 1'b1);
         chk("start", lastStart, 4'he);
         chk("wrcnt", wrCnt, k + 1);
         chk("waits", waitCnt, 2 * k);
      end
      hub(1'b0, 4'h9, 28'h0f0_0001, 8'h00, got);
      chk("rdone", got, 1'b1);
      chk("rstart", lastStart, 4'hd);
      chk("rdcnt", rdCnt, 1);
      chk("rarray", toArray, 1'b1);
      chk("raddr", accAddr, 23'h1);
      hub(1'b1, 4'h6, 28'h000_0777, 8'h11, got);
      chk("nomatch", got, 1'b0);
      chk("nowr", wrCnt, 2);
      for (int c = 4; c < 8; c++) begin
         adr = {8'ha5, c[0], 5'h1f, 18'h1_2345 + 18'(c)};
         lpc(4'(c), adr, 8);
         chk("lpcaddr", accAddrB, {5'h0, adr[17:0]});
         chk("array", toArrayB, adr[23]);
         chk("lpckind", isHubB, 1'b0);
         chk("lpcstart", lastStartB, 4'h0);
      end
      lpc(4'h6, 32'hffff_ffff, 3);
      lpc(4'h6, 32'h0000_1111, 8);
      chk("abort", accAddrB, 23'h1111);
      opBusy = 1'b1;
      devSeen = 1'b0;
      lpc(4'h2, 32'h0080_0000, 8);
      chk("busy", standbyB, 1'b0);
      opBusy = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      chk("stby", standbyB, 1'b1);
      chk("float", devSeen, 1'b0);
      finish_test;
   end
   initial begin
      #20000;
      fails++;
      finish_test;
   end
endmodule
`default_nettype wire
